// [hw/irtx_defines.svh]
// Register offsets, field positions and reset values of the IR transmit unit
`ifndef IRTX_DEFINES_SVH
`define IRTX_DEFINES_SVH
// Byte offsets of the registers
`define IRTX_OFS_CLKCTL   5'h00
`define IRTX_OFS_CARRIER  5'h04
`define IRTX_OFS_ACTLEN   5'h08
`define IRTX_OFS_SYMLEN   5'h0C
`define IRTX_OFS_CTRL     5'h10
`define IRTX_OFS_COUNT    5'h14
`define IRTX_OFS_FLAGS    5'h18
`define IRTX_OFS_IRQEN    5'h1C
// Clock control fields
`define IRTX_CLK_DBGRUN   8
`define IRTX_CLK_DIV      7:4
`define IRTX_CLK_SRC      1:0
// Carrier fields
`define IRTX_CAR_DUTY     7:0
`define IRTX_CAR_PER      15:8
// Control fields
`define IRTX_CTL_CRST     9
`define IRTX_CTL_RUN      8
`define IRTX_CTL_INV      4
`define IRTX_CTL_SHADOW   3
`define IRTX_CTL_ONESHOT  2
`define IRTX_CTL_SRST     1
`define IRTX_CTL_ENABLE   0
// Flag fields
`define IRTX_FLG_DB       0
`define IRTX_FLG_AP       1
`define IRTX_FLG_APBSY    8
`define IRTX_FLG_DBBSY    9
// Reset values
`define IRTX_RST8         8'h00
`define IRTX_RST16        16'h0000
`define IRTX_RST32        32'h0000_0000
`endif

// [hw/irtx_pkg.sv]
// Types shared by the IR transmit unit
package irtx_pkg;
    // Bus answer phase, Gray coded
    typedef enum logic [0:0] {
        IRTX_BUS_IDLE = 1'b0,
        IRTX_BUS_ACK  = 1'b1
    } irtx_bus_t;
endpackage

// [hw/irtx_clk_div.sv]
// Operating clock divider producing a one-cycle tick enable
`timescale 1ns/1ps
`include "irtx_defines.svh"
module irtx_clk_div
    import irtx_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [3:0] div_sel_i,
    // Tick
    output logic            tick_o
);
    logic [DIV_W-1:0] cnt;   // Free prescaler
    logic [DIV_W-1:0] mask;  // Low bits that must all be ones

    // Ratio is two to the power of the selection
    always_comb begin
        mask = DIV_W'((32'h1 << div_sel_i) - 32'h1);
    end

    // Prescaler advances only while the unit is clocked
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= '0;
        end else if (run_i) begin
            cnt <= cnt + DIV_W'(1);
        end
    end

    // Tick when all selected low bits are set
    assign tick_o = run_i & ((cnt & mask) == mask);
endmodule // irtx_clk_div

// [hw/irtx_carrier.sv]
// Carrier generator with 8-bit counter
`timescale 1ns/1ps
`include "irtx_defines.svh"
module irtx_carrier
    import irtx_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       clr_i,
    input  wire logic       step_i,
    input  wire logic [7:0] duty_i,
    input  wire logic [7:0] period_i,
    // Carrier level
    output logic            level_o
);
    logic [7:0] cnt;  // Carrier counter

    // Counter wraps to zero on the period match
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= `IRTX_RST8;
        end else if (clr_i) begin
            cnt <= `IRTX_RST8;
        end else if (step_i) begin
            if (cnt == period_i) begin
                cnt <= `IRTX_RST8;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    // Level starts high, toggles at duty and at period
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_o <= 1'b1;
        end else if (clr_i) begin
            level_o <= 1'b1;
        end else if (step_i && (cnt == duty_i || cnt == period_i)) begin
            level_o <= ~level_o;
        end
    end
endmodule // irtx_carrier

// [hw/irtx_unit.sv]
// IR remote transmit unit: registers, data counter, output shaping
// Operation
// - Output is carrier AND data, then inverted if invert is set
// - Carrier toggles when counter equals duty
// - Period match toggles carrier, counter returns zero
// - Carrier lasts period+1, high duty+1 cycles
// - Carrier counter cleared, run with data counter
// - Data toggles when counter equals active length
// - Length match toggles data, counter returns zero
// - Symbol lasts length+1, active part active+1
// - Repeat mode cycles until run is cleared
// - One-shot mode halts on first length match
// - Unbuffered compare uses live length registers
// - Buffered compare uses shadows reloaded at end
// - Busy flag set on write, cleared on reload
// - Active match flag, cleared by one or reset
// - Symbol end flag, cleared by one or reset
// - Interrupt only while an enabled flag set
// - Outputs carry waveforms only while running
// - Clear pulse high during inactive symbol part
// - Debug-run bit keeps clock during debug halt
// - Invert control inverts the transmit output
// - Soft reset clears counters and flags, self-clears; the length busy flags are kept
// - One-shot end clears the run control
// - Counter reset reads one while in progress
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "irtx_defines.svh"
module irtx_unit
    import irtx_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Processor debug halt
    input  wire logic        dbg_halt_i,
    // Pins and interrupt
    output logic             ir_tx_out_o,
    output logic             clear_pulse_out_o,
    output logic             irq_o
);
    irtx_bus_t   bus_st;             // Bus answer phase
    logic        acc;                // Access completes this edge
    logic        wr_go;              // Write completes this edge
    logic [15:0] wd;                 // Write data with lanes masked
    logic [15:0] wm;                 // Lane mask
    logic [15:0] rd_mux;             // Read data select
    logic        debug_run;          // Clock kept in debug halt
    logic [3:0]  clk_divide;         // Division ratio select
    logic [1:0]  clk_source;         // Source select, stored only
    logic [7:0]  carrier_duty;       // Carrier duty compare
    logic [7:0]  carrier_period;     // Carrier period compare
    logic [15:0] active_len;         // Active length register
    logic [15:0] symbol_len;         // Symbol length register
    logic [15:0] sh_active;          // Active length shadow
    logic [15:0] sh_symbol;          // Symbol length shadow
    logic        unit_enable;        // Operating clock gate
    logic        oneshot_sel;        // One-shot mode
    logic        shadow_enable;      // Compare buffering
    logic        out_invert;         // Output inversion
    logic        run_ctrl;           // Counting
    logic        cnt_rst;            // Counter reset pending
    logic        soft_reset;         // Soft reset in progress
    logic [15:0] symbol_count;       // Data counter
    logic        data_lvl;           // Data waveform, high is active
    logic        active_match_flag;  // Compare active event
    logic        symbol_end_flag;    // Compare symbol end event
    logic        active_len_busy;    // Active length awaits reload
    logic        symbol_len_busy;    // Symbol length awaits reload
    logic [1:0]  irq_en;             // Interrupt enables
    logic        tick;               // Operating clock enable
    logic        car_lvl;            // Carrier waveform
    logic        clr_cnt;            // Clear both counters
    logic        run_tick;           // Counting step
    logic [15:0] cmp_ap;             // Active compare value
    logic [15:0] cmp_db;             // Symbol compare value
    logic        hit_ap;             // Compare active event
    logic        hit_db;             // Compare symbol end event
    logic        wr_clk;             // Write strobes
    logic        wr_car;
    logic        wr_alen;
    logic        wr_slen;
    logic        wr_ctrl;
    logic        wr_flag;
    logic        wr_ien;

    // Address match for completed writes; every input is an argument so strobes follow the bus
    function automatic logic wr_at(input logic go, input logic [4:0] adr,
                                   input logic [4:0] ofs);
        return go & (adr == ofs);
    endfunction

    // One wait state, then the access completes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_st <= IRTX_BUS_IDLE;
        end else if ((avs_read_i | avs_write_i) && bus_st == IRTX_BUS_IDLE) begin
            bus_st <= IRTX_BUS_ACK;
        end else begin
            bus_st <= IRTX_BUS_IDLE;
        end
    end
    assign acc = bus_st == IRTX_BUS_ACK;
    assign wr_go = avs_write_i & acc;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc;
    assign wm = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wd = avs_writedata_i[15:0] & wm;
    assign wr_clk  = wr_at(wr_go, avs_address_i, `IRTX_OFS_CLKCTL) & ~unit_enable;
    assign wr_car  = wr_at(wr_go, avs_address_i, `IRTX_OFS_CARRIER);
    assign wr_alen = wr_at(wr_go, avs_address_i, `IRTX_OFS_ACTLEN) & unit_enable;
    assign wr_slen = wr_at(wr_go, avs_address_i, `IRTX_OFS_SYMLEN) & unit_enable;
    assign wr_ctrl = wr_at(wr_go, avs_address_i, `IRTX_OFS_CTRL);
    assign wr_flag = wr_at(wr_go, avs_address_i, `IRTX_OFS_FLAGS);
    assign wr_ien  = wr_at(wr_go, avs_address_i, `IRTX_OFS_IRQEN);

    // Read data select, unmapped reads as zero
    always_comb begin
        rd_mux = `IRTX_RST16;
        unique case (avs_address_i)
            `IRTX_OFS_CLKCTL: begin
                rd_mux[`IRTX_CLK_DBGRUN] = debug_run;
                rd_mux[`IRTX_CLK_DIV]    = clk_divide;
                rd_mux[`IRTX_CLK_SRC]    = clk_source;
            end
            `IRTX_OFS_CARRIER: rd_mux = {carrier_period, carrier_duty};
            `IRTX_OFS_ACTLEN:  rd_mux = active_len;
            `IRTX_OFS_SYMLEN:  rd_mux = symbol_len;
            `IRTX_OFS_CTRL: begin
                rd_mux[`IRTX_CTL_CRST]    = cnt_rst;
                rd_mux[`IRTX_CTL_RUN]     = run_ctrl;
                rd_mux[`IRTX_CTL_INV]     = out_invert;
                rd_mux[`IRTX_CTL_SHADOW]  = shadow_enable;
                rd_mux[`IRTX_CTL_ONESHOT] = oneshot_sel;
                rd_mux[`IRTX_CTL_SRST]    = soft_reset;
                rd_mux[`IRTX_CTL_ENABLE]  = unit_enable;
            end
            `IRTX_OFS_COUNT: rd_mux = symbol_count;
            `IRTX_OFS_FLAGS: begin
                rd_mux[`IRTX_FLG_DB]    = symbol_end_flag;
                rd_mux[`IRTX_FLG_AP]    = active_match_flag;
                rd_mux[`IRTX_FLG_APBSY] = active_len_busy;
                rd_mux[`IRTX_FLG_DBBSY] = symbol_len_busy;
            end
            `IRTX_OFS_IRQEN: rd_mux = {14'h0000, irq_en};
            default: rd_mux = `IRTX_RST16;
        endcase
    end

    // Read data captured in the wait cycle, stands at completion
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= `IRTX_RST32;
        end else if (avs_read_i && !acc) begin
            avs_readdata_o <= {16'h0000, rd_mux};
        end
    end

    // Configuration registers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            debug_run      <= 1'b0;
            clk_divide     <= 4'h0;
            clk_source     <= 2'h0;
            carrier_duty   <= `IRTX_RST8;
            carrier_period <= `IRTX_RST8;
            irq_en         <= 2'h0;
            unit_enable    <= 1'b0;
            oneshot_sel    <= 1'b0;
            shadow_enable  <= 1'b0;
            out_invert     <= 1'b0;
        end else begin
            if (wr_clk) begin
                debug_run  <= wd[`IRTX_CLK_DBGRUN];
                clk_divide <= wd[`IRTX_CLK_DIV];
                clk_source <= wd[`IRTX_CLK_SRC];
            end
            if (wr_car) begin
                carrier_duty   <= wd[`IRTX_CAR_DUTY];
                carrier_period <= wd[`IRTX_CAR_PER];
            end
            if (wr_ien) begin
                irq_en <= wd[1:0];
            end
            if (wr_ctrl) begin
                unit_enable   <= wd[`IRTX_CTL_ENABLE];
                oneshot_sel   <= wd[`IRTX_CTL_ONESHOT];
                shadow_enable <= wd[`IRTX_CTL_SHADOW];
                out_invert    <= wd[`IRTX_CTL_INV];
            end
        end
    end

    // Length registers, lanes merged
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_len <= `IRTX_RST16;
            symbol_len <= `IRTX_RST16;
        end else begin
            if (wr_alen) begin
                active_len <= (active_len & ~wm) | wd;
            end
            if (wr_slen) begin
                symbol_len <= (symbol_len & ~wm) | wd;
            end
        end
    end

    // Shadows follow live values unless buffering holds them
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_active <= `IRTX_RST16;
            sh_symbol <= `IRTX_RST16;
        end else if (!shadow_enable || hit_db) begin
            sh_active <= active_len;
            sh_symbol <= symbol_len;
        end
    end
    assign cmp_ap = shadow_enable ? sh_active : active_len;
    assign cmp_db = shadow_enable ? sh_symbol : symbol_len;

    // Busy flags, a new write beats the reload clear
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_len_busy <= 1'b0;
            symbol_len_busy <= 1'b0;
        end else begin
            if (wr_alen && shadow_enable) begin
                active_len_busy <= 1'b1;
            end else if (hit_db || !shadow_enable) begin
                active_len_busy <= 1'b0;
            end
            if (wr_slen && shadow_enable) begin
                symbol_len_busy <= 1'b1;
            end else if (hit_db || !shadow_enable) begin
                symbol_len_busy <= 1'b0;
            end
        end
    end

    // Soft reset lasts one cycle after the write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= wr_ctrl & wd[`IRTX_CTL_SRST];
        end
    end

    // Counter reset pending until the next operating tick
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_rst <= 1'b0;
        end else if (soft_reset) begin
            cnt_rst <= 1'b0;
        end else if (wr_ctrl && wd[`IRTX_CTL_CRST] && unit_enable) begin
            cnt_rst <= 1'b1;
        end else if (tick) begin
            cnt_rst <= 1'b0;
        end
    end

    // Run control, a write wins over the one-shot stop
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_ctrl <= 1'b0;
        end else if (soft_reset) begin
            run_ctrl <= 1'b0;
        end else if (wr_ctrl && avs_byteenable_i[1]) begin
            run_ctrl <= wd[`IRTX_CTL_RUN] & unit_enable;
        end else if (hit_db && oneshot_sel) begin
            run_ctrl <= 1'b0;
        end
    end

    // Operating clock enable, halted in debug unless allowed
    irtx_clk_div u_div (
        .mclk_i    (mclk_i),
        .nrst_i    (nrst_i),
        .run_i     (unit_enable & (~dbg_halt_i | debug_run)),
        .div_sel_i (clk_divide),
        .tick_o    (tick)
    );
    assign clr_cnt  = soft_reset | (cnt_rst & tick);
    assign run_tick = tick & run_ctrl & ~clr_cnt;
    assign hit_ap   = run_tick & (symbol_count == cmp_ap);
    assign hit_db   = run_tick & (symbol_count == cmp_db);

    // Carrier steps in step with the data counter
    irtx_carrier u_car (
        .mclk_i   (mclk_i),
        .nrst_i   (nrst_i),
        .clr_i    (clr_cnt),
        .step_i   (run_tick),
        .duty_i   (carrier_duty),
        .period_i (carrier_period),
        .level_o  (car_lvl)
    );

    // Data counter wraps on symbol end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            symbol_count <= `IRTX_RST16;
        end else if (clr_cnt || hit_db) begin
            symbol_count <= `IRTX_RST16;
        end else if (run_tick) begin
            symbol_count <= symbol_count + 16'h0001;
        end
    end

    // Data level active from zero, toggled by either match alone, held if both coincide
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_lvl <= 1'b1;
        end else if (clr_cnt) begin
            data_lvl <= 1'b1;
        end else if (hit_ap ^ hit_db) begin
            data_lvl <= ~data_lvl;
        end
    end

    // Event flags, set beats the write-one clear
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_match_flag <= 1'b0;
            symbol_end_flag   <= 1'b0;
        end else if (soft_reset) begin
            active_match_flag <= 1'b0;
            symbol_end_flag   <= 1'b0;
        end else begin
            if (hit_ap) begin
                active_match_flag <= 1'b1;
            end else if (wr_flag && wd[`IRTX_FLG_AP]) begin
                active_match_flag <= 1'b0;
            end
            if (hit_db) begin
                symbol_end_flag <= 1'b1;
            end else if (wr_flag && wd[`IRTX_FLG_DB]) begin
                symbol_end_flag <= 1'b0;
            end
        end
    end

    // Registered pins and interrupt request
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ir_tx_out_o       <= 1'b0;
            clear_pulse_out_o <= 1'b0;
            irq_o             <= 1'b0;
        end else begin
            ir_tx_out_o       <= run_ctrl & ((car_lvl & data_lvl) ^ out_invert);
            clear_pulse_out_o <= run_ctrl & ~data_lvl;
            irq_o <= (symbol_end_flag & irq_en[`IRTX_FLG_DB])
                   | (active_match_flag & irq_en[`IRTX_FLG_AP]);
        end
    end

    // Checks
    property p_idle_out;
        @(posedge mclk_i) disable iff (!nrst_i)
        !run_ctrl |=> !ir_tx_out_o && !clear_pulse_out_o;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("pin active while stopped");
    property p_irq;
        @(posedge mclk_i) disable iff (!nrst_i)
        (symbol_end_flag && irq_en[0]) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled flag without irq");
    property p_wrap;
        @(posedge mclk_i) disable iff (!nrst_i)
        hit_db |=> symbol_count == 16'h0000 && data_lvl;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at symbol end");
    property p_oneshot;
        @(posedge mclk_i) disable iff (!nrst_i)
        hit_db && oneshot_sel && !wr_ctrl |=> !run_ctrl ##1 $stable(symbol_count);
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");
    property p_flag_db;
        @(posedge mclk_i) disable iff (!nrst_i)
        hit_db && !soft_reset |=> symbol_end_flag;
    endproperty
    a_flag_db: assert property (p_flag_db) else $error("symbol end flag missed");
    property p_flag_ap;
        @(posedge mclk_i) disable iff (!nrst_i)
        hit_ap && !soft_reset |=> active_match_flag && !data_lvl;
    endproperty
    a_flag_ap: assert property (p_flag_ap) else $error("active match missed");
    property p_busy;
        @(posedge mclk_i) disable iff (!nrst_i)
        wr_alen && shadow_enable |=> active_len_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_hold;
        @(posedge mclk_i) disable iff (!nrst_i)
        !run_ctrl && !clr_cnt |=> $stable(symbol_count);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while stopped");
    property p_soft;
        @(posedge mclk_i) disable iff (!nrst_i)
        soft_reset |=> symbol_count == 16'h0000 && !symbol_end_flag && !soft_reset;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset incomplete");
    c_oneshot: cover property (@(posedge mclk_i) disable iff (!nrst_i) hit_db && oneshot_sel);
    c_reload:  cover property (@(posedge mclk_i) disable iff (!nrst_i) hit_db && shadow_enable);
    c_irq:     cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(irq_o));
endmodule // irtx_unit

// [test/irtx_emitter_model.sv]
// Emitter and lamp driver stand-in that times the high pulses on both pins
`timescale 1ns/1ps
module irtx_emitter_model (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Pins from the unit
    input  wire logic        ir_tx_out_i,
    input  wire logic        clear_pulse_out_i,
    // Width of the last finished high pulse, in clock cycles
    output logic [15:0]      tx_width_o,
    output logic [15:0]      clr_width_o
);
    logic [15:0] tx_run;   // High time so far on the emitter drive
    logic [15:0] clr_run;  // High time so far on the lamp clear pulse
    // Time each lit burst and each clear pulse, keep the last width
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_run      <= 16'h0000;
            clr_run     <= 16'h0000;
            tx_width_o  <= 16'h0000;
            clr_width_o <= 16'h0000;
        end else begin
            tx_run  <= ir_tx_out_i ? tx_run + 16'h0001 : 16'h0000;
            clr_run <= clear_pulse_out_i ? clr_run + 16'h0001 : 16'h0000;
            // A falling pin closes the pulse
            if (!ir_tx_out_i && tx_run != 16'h0000) tx_width_o <= tx_run;
            if (!clear_pulse_out_i && clr_run != 16'h0000) clr_width_o <= clr_run;
        end
    end
endmodule // irtx_emitter_model

// [test/testbench.sv]
// Self-checking bench: one-shot symbols with random lengths, flags and pins
`timescale 1ns/1ps
`include "irtx_defines.svh"
module testbench;
    logic        mclk_i = 1'b0;       // System clock
    logic        nrst_i = 1'b0;       // Reset, active low
    logic [4:0]  adr = 5'h00;         // Bus address
    logic        rd = 1'b0;           // Bus read
    logic        wr = 1'b0;           // Bus write
    logic [31:0] wdat = 32'h0;        // Bus write data
    logic [31:0] rdat;                // Bus read data
    logic        wait_o;              // Bus wait request
    logic        tx, clr, irq;        // Pins and interrupt
    logic [15:0] txw, clrw;           // Widths seen by the emitter
    logic [31:0] expq[$];             // Expected read data, oldest first
    int          fails = 0;           // Mismatch count
    int          checks = 0;          // Comparison count
    int          cyc = 0;             // Cycle counter for the timeout
    logic [15:0] sl, al;              // Symbol and active lengths
    logic        halt = 1'b0;         // Processor debug halt
    always #10 mclk_i = ~mclk_i;
    irtx_unit u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .dbg_halt_i(halt), .ir_tx_out_o(tx), .clear_pulse_out_o(clr), .irq_o(irq));
    irtx_emitter_model u_emit (.mclk_i(mclk_i), .nrst_i(nrst_i), .ir_tx_out_i(tx),
        .clear_pulse_out_i(clr), .tx_width_o(txw), .clr_width_o(clrw));
    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus access, held until wait request is low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        adr  <= a;
        wdat <= d;
        rd   <= !w;
        wr   <= w;
        do @(posedge mclk_i); while (wait_o !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Read with the expectation noted first
    task automatic rd_exp(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Watch read answers and compare against the oldest note
    always @(posedge mclk_i)
        if (rd && wait_o === 1'b0) check(rdat, expq.pop_front());
    // Print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h8689e943));
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd_exp(`IRTX_OFS_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            sl = 16'h0004 + 16'($urandom % 12);
            al = 16'($urandom % sl);
            bus(1'b1, `IRTX_OFS_CTRL, 32'h0);
            bus(1'b1, `IRTX_OFS_CLKCTL, 32'h0100);
            rd_exp(`IRTX_OFS_CLKCTL, 32'h0100);
            bus(1'b1, `IRTX_OFS_CTRL, 32'h5 | (i[0] << 4));
            bus(1'b1, `IRTX_OFS_CARRIER, 32'hFFFE);
            bus(1'b1, `IRTX_OFS_ACTLEN, {16'h0, al});
            bus(1'b1, `IRTX_OFS_SYMLEN, {16'h0, sl});
            bus(1'b1, `IRTX_OFS_IRQEN, 32'h3);
            // Compare buffering is switched on only after the lengths are in place
            bus(1'b1, `IRTX_OFS_CTRL, 32'h205 | (i[0] << 4) | (i[1] << 3));
            bus(1'b1, `IRTX_OFS_CTRL, 32'h105 | (i[0] << 4) | (i[1] << 3));
            repeat (sl + 10) @(posedge mclk_i);
            rd_exp(`IRTX_OFS_CTRL, 32'h5 | (i[0] << 4) | (i[1] << 3));
            rd_exp(`IRTX_OFS_FLAGS, 32'h3);
            rd_exp(`IRTX_OFS_COUNT, 32'h0);
            check(irq, 1'b1);
            check(txw, i[0] ? sl - al : al + 16'h1);
            check(clrw, sl - al);
            check(tx, 1'b0);
            bus(1'b1, `IRTX_OFS_IRQEN, 32'h0);
            repeat (2) @(posedge mclk_i);
            check(irq, 1'b0);
            bus(1'b1, `IRTX_OFS_FLAGS, {31'h0, i[1]});
            rd_exp(`IRTX_OFS_FLAGS, i[1] ? 32'h2 : 32'h3);
            bus(1'b1, `IRTX_OFS_CTRL, 32'h3);
            rd_exp(`IRTX_OFS_FLAGS, 32'h0);
            $display("test %0d done", i);
        end
        // Debug halt without the debug-run bit freezes the counter
        bus(1'b1, `IRTX_OFS_CTRL, 32'h0);
        bus(1'b1, `IRTX_OFS_CLKCTL, 32'h0);
        bus(1'b1, `IRTX_OFS_CTRL, 32'h1);
        halt <= 1'b1;
        bus(1'b1, `IRTX_OFS_CTRL, 32'h101);
        repeat (5) @(posedge mclk_i);
        rd_exp(`IRTX_OFS_COUNT, 32'h0);
        halt <= 1'b0;
        rd_exp(`IRTX_OFS_COUNT, 32'h1);
        $display("test halt done");
        give_verdict();
    end
endmodule // testbench
